// [dpc_pkg.sv]
// Package of constants and types for the debug port control and status registers
// Behaviour
// RULE1: Control/status bit 31 reads the synchronised system power-up acknowledge level.
// RULE2: Control/status bit 30, reset 0, drives the system power-up request output.
// RULE3: Control/status bit 29 reads the synchronised debug power-up acknowledge level.
// RULE4: Control/status bit 28, reset 0, drives the debug power-up request output.
// RULE5: Control/status bit 27 reads the synchronised debug reset acknowledge level.
// RULE6: Control/status bit 26, reset 0, drives the debug reset request output.
// RULE7: Error mode bit 24 set stops port errors from setting the sticky error flag.
// RULE8: Serial wire only: bit 7 sets on write data phase error or dropped write.
// RULE9: Write data error flag clears only by abort write data error clear.
// RULE10: Serial wire only: bit 6 follows whether the last read response was OK.
// RULE11: In JTAG variant bits 7 and 6 are reserved and read zero.
// RULE12: Sticky error bit 5 sets on port error while error mode is 0.
// RULE13: JTAG clears sticky error by W1C or abort; serial wire only by abort.
// RULE14: Control/status bit 0 enables overrun detection.
// RULE15: Sticky overrun bit 1 sets on overrun while detection is enabled.
// RULE16: JTAG clears sticky overrun by W1C or abort; serial wire only by abort.
// RULE17: Link control register exists only in serial wire variant, else reads zero.
// RULE18: Turnaround field 9:8 gives 1 to 4 link data periods of turnaround.
// RULE19: Target ident returns tie-off revision, part number, designer; bit 0 reads one.
// RULE20: Debugger picks the bank at offset 0x4 with the select bank field.
// RULE21: Abort bit 4 written one clears the sticky overrun flag.
// RULE22: Acknowledge inputs pass a two-stage synchroniser before being read.
// RULE23: Request outputs hold until rewritten, whatever the acknowledges do.
package dpc_pkg;
    localparam logic [3:0]  CTRL_OFFSET     = 4'h4;
    localparam logic [3:0]  BANK_CTRL       = 4'h0;
    localparam logic [3:0]  BANK_LINK       = 4'h1;
    localparam logic [3:0]  BANK_TARGET     = 4'h2;
    localparam logic [3:0]  BANK_PROTOCOL   = 4'h3;
    localparam int          SYS_ACK_BIT     = 31;
    localparam int          SYS_REQ_BIT     = 30;
    localparam int          DBG_ACK_BIT     = 29;
    localparam int          DBG_REQ_BIT     = 28;
    localparam int          RST_ACK_BIT     = 27;
    localparam int          RST_REQ_BIT     = 26;
    localparam int          ERR_MODE_BIT    = 24;
    localparam int          WDATA_ERR_BIT   = 7;
    localparam int          READ_OK_BIT     = 6;
    localparam int          STICKY_ERR_BIT  = 5;
    localparam int          STICKY_ORUN_BIT = 1;
    localparam int          ORUN_EN_BIT     = 0;
    localparam int          TURN_LSB        = 8;
    localparam int          LINK_RES1_BIT   = 6;
    localparam int          TARGET_ONE_BIT  = 0;
    localparam int          ABORT_ORUN_BIT  = 4;
    localparam int          ABORT_WDE_BIT   = 3;
    localparam int          ABORT_STK_BIT   = 2;
    localparam logic [1:0]  TURN_RESET      = 2'h0;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] LINK_CTRL_RESET = 32'h0000_0040;
    // Protocol version nibble of the link protocol ident
    localparam logic [31:0] PROTOCOL_IDENT  = 32'h0000_0001;

    typedef enum logic [0:0] {
        DPC_TURN_IDLE  = 1'b0,
        DPC_TURN_COUNT = 1'b1
    } dpc_turn_state_t;

    typedef struct packed {
        logic        sys_req;
        logic        dbg_req;
        logic        rst_req;
        logic        err_mode;
        logic        wdata_err;
        logic        read_ok;
        logic        sticky_err;
        logic        sticky_orun;
        logic        orun_en;
        logic [1:0]  turn;
        logic [31:0] rdata;
        logic        rdata_valid;
    } dpc_regs_t;
endpackage

// [dpc_sync.sv]
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/100ps
`default_nettype none
module dpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } dpc_sync_t;

    dpc_sync_t st;
    dpc_sync_t next_st;

    // First stage feeds only the second
    always_comb begin
        next_st.stage1 = d;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stage2;
endmodule
`default_nettype wire

// [dpc_turnaround.sv]
// Turnaround timer counting link clock periods after a start pulse
`timescale 1ns/100ps
`default_nettype none
module dpc_turnaround (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       link_clk_sync,
    input  wire logic       start,
    input  wire logic [1:0] length,
    output logic            active
);
    typedef struct packed {
        dpc_pkg::dpc_turn_state_t state;
        logic [2:0]               left;
        logic                     link_prev;
        logic                     active;
    } dpc_turn_t;

    dpc_turn_t st;
    dpc_turn_t next_st;
    logic      rise;

    assign rise = link_clk_sync && !st.link_prev;

    always_comb begin
        next_st = st;
        next_st.link_prev = link_clk_sync;
        unique case (st.state)
            dpc_pkg::DPC_TURN_IDLE: begin
                if (start) begin
                    // Field value n gives n+1 periods, see RULE18
                    next_st.left   = {1'b0, length} + 3'h1;
                    next_st.state  = dpc_pkg::DPC_TURN_COUNT;
                    next_st.active = 1'b1;
                end
            end
            dpc_pkg::DPC_TURN_COUNT: begin
                if (rise) begin
                    next_st.left = st.left - 3'h1;
                    if (st.left == 3'h1) begin
                        next_st.state  = dpc_pkg::DPC_TURN_IDLE;
                        next_st.active = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{dpc_pkg::DPC_TURN_IDLE, 3'h0, 1'b0, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;

    a_turn_ends_on_edge: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE18
        $fell(st.active) |-> $past(rise))
        else $error("turnaround ended without a link clock edge");
endmodule
`default_nettype wire

// [dpc_ctrl_status.sv]
// Debug port control/status, link control and target ident registers
`timescale 1ns/100ps
`default_nettype none
module dpc_ctrl_status #(
    parameter bit SERIAL_WIRE = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic [3:0]  port_bank_select,
    input  wire logic        abort_wr,
    input  wire logic [31:0] abort_wdata,
    input  wire logic        ap_error,
    input  wire logic        overrun_event,
    input  wire logic        write_data_error_event,
    input  wire logic        read_resp_valid,
    input  wire logic        read_resp_ok,
    input  wire logic        system_power_up_ack,
    input  wire logic        debug_power_up_ack,
    input  wire logic        debug_reset_ack,
    input  wire logic [31:0] target_tie,
    input  wire logic        link_clk,
    input  wire logic        turnaround_start,
    output logic             system_power_up_req,
    output logic             debug_power_up_req,
    output logic             debug_reset_req,
    output logic             error_report_mode,
    output logic             overrun_detect_enable,
    output logic [1:0]       turnaround_length,
    output logic             turnaround_active,
    output logic [31:0]      reg_rdata,
    output logic             reg_rdata_valid
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]  rst_pipe;
    logic        rst_n;
    logic [3:0]  pin_sync;
    logic [31:0] target_sync;
    logic        sys_ack;
    logic        dbg_ack;
    logic        rst_ack;
    logic        link_clk_sync;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Acks and link clock arrive from other domains, see RULE22
    dpc_sync #(.WIDTH(4)) u_pin_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({system_power_up_ack, debug_power_up_ack, debug_reset_ack, link_clk}),
        .q       (pin_sync)
    );
    assign {sys_ack, dbg_ack, rst_ack, link_clk_sync} = pin_sync;

    // Tie-offs are static but still cross before use
    dpc_sync #(.WIDTH(32)) u_target_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (target_tie),
        .q       (target_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    dpc_pkg::dpc_regs_t st;
    dpc_pkg::dpc_regs_t next_st;

    // Only the offset shared by the banked registers lives here, see RULE20
    function automatic logic hits(input logic [3:0] addr, input logic [3:0] bank,
                                  input logic [3:0] want);
        hits = (addr == dpc_pkg::CTRL_OFFSET) && (bank == want);
    endfunction

    logic        wr_ctrl;
    logic        wr_link;
    logic        stk_set;
    logic        stk_clr;
    logic        orun_set;
    logic        orun_clr;
    logic        wde_set;
    logic        wde_clr;
    logic [31:0] ctrl_value;
    logic [31:0] link_value;
    logic [31:0] target_value;

    assign wr_ctrl = reg_wr && hits(reg_addr, port_bank_select, dpc_pkg::BANK_CTRL);
    assign wr_link = reg_wr && hits(reg_addr, port_bank_select, dpc_pkg::BANK_LINK)
                     && SERIAL_WIRE;

    assign stk_set  = ap_error && !st.err_mode; // see RULE7 see RULE12
    assign stk_clr  = (abort_wr && abort_wdata[dpc_pkg::ABORT_STK_BIT])
                      || (!SERIAL_WIRE && wr_ctrl
                          && reg_wdata[dpc_pkg::STICKY_ERR_BIT]); // see RULE13
    assign orun_set = overrun_event && st.orun_en; // see RULE15
    assign orun_clr = (abort_wr && abort_wdata[dpc_pkg::ABORT_ORUN_BIT]) // see RULE21
                      || (!SERIAL_WIRE && wr_ctrl
                          && reg_wdata[dpc_pkg::STICKY_ORUN_BIT]); // see RULE16
    assign wde_set  = SERIAL_WIRE && write_data_error_event; // see RULE8
    assign wde_clr  = abort_wr && abort_wdata[dpc_pkg::ABORT_WDE_BIT]; // see RULE9

    always_comb begin
        ctrl_value = 32'h0000_0000;
        ctrl_value[dpc_pkg::SYS_ACK_BIT]     = sys_ack; // see RULE1
        ctrl_value[dpc_pkg::SYS_REQ_BIT]     = st.sys_req;
        ctrl_value[dpc_pkg::DBG_ACK_BIT]     = dbg_ack; // see RULE3
        ctrl_value[dpc_pkg::DBG_REQ_BIT]     = st.dbg_req;
        ctrl_value[dpc_pkg::RST_ACK_BIT]     = rst_ack; // see RULE5
        ctrl_value[dpc_pkg::RST_REQ_BIT]     = st.rst_req;
        ctrl_value[dpc_pkg::ERR_MODE_BIT]    = st.err_mode;
        ctrl_value[dpc_pkg::WDATA_ERR_BIT]   = st.wdata_err;
        ctrl_value[dpc_pkg::READ_OK_BIT]     = st.read_ok;
        ctrl_value[dpc_pkg::STICKY_ERR_BIT]  = st.sticky_err;
        ctrl_value[dpc_pkg::STICKY_ORUN_BIT] = st.sticky_orun;
        ctrl_value[dpc_pkg::ORUN_EN_BIT]     = st.orun_en;
        link_value = 32'h0000_0000;
        if (SERIAL_WIRE) begin // see RULE17
            link_value = dpc_pkg::LINK_CTRL_RESET;
            link_value[dpc_pkg::TURN_LSB +: 2] = st.turn;
        end
        target_value = target_sync;
        target_value[dpc_pkg::TARGET_ONE_BIT] = 1'b1; // see RULE19
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        if (wr_ctrl) begin
            // Requests change only on a write, never on an ack, see RULE23
            next_st.sys_req  = reg_wdata[dpc_pkg::SYS_REQ_BIT]; // see RULE2
            next_st.dbg_req  = reg_wdata[dpc_pkg::DBG_REQ_BIT]; // see RULE4
            next_st.rst_req  = reg_wdata[dpc_pkg::RST_REQ_BIT]; // see RULE6
            next_st.err_mode = reg_wdata[dpc_pkg::ERR_MODE_BIT]; // see RULE7
            next_st.orun_en  = reg_wdata[dpc_pkg::ORUN_EN_BIT]; // see RULE14
        end
        if (wr_link) begin
            next_st.turn = reg_wdata[dpc_pkg::TURN_LSB +: 2]; // see RULE18
        end
        // Hardware set wins over a clear in the same cycle
        next_st.sticky_err  = stk_set || (st.sticky_err && !stk_clr);
        next_st.sticky_orun = orun_set || (st.sticky_orun && !orun_clr);
        next_st.wdata_err   = wde_set || (st.wdata_err && !wde_clr);
        if (SERIAL_WIRE && read_resp_valid) begin
            next_st.read_ok = read_resp_ok; // see RULE10
        end
        if (!SERIAL_WIRE) begin // see RULE11
            next_st.wdata_err = 1'b0;
            next_st.read_ok   = 1'b0;
        end
        next_st.rdata_valid = reg_rd;
        if (reg_rd) begin
            if (reg_addr != dpc_pkg::CTRL_OFFSET) begin
                next_st.rdata = 32'h0000_0000;
            end else begin
                unique case (port_bank_select)
                    dpc_pkg::BANK_CTRL:     next_st.rdata = ctrl_value;
                    dpc_pkg::BANK_LINK:     next_st.rdata = link_value;
                    dpc_pkg::BANK_TARGET:   next_st.rdata = target_value;
                    dpc_pkg::BANK_PROTOCOL: next_st.rdata = dpc_pkg::PROTOCOL_IDENT;
                    default:                next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.turn <= dpc_pkg::TURN_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic turn_active;

    // Link clock is sampled, so periods are seen as its rising edges
    dpc_turnaround u_turnaround (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .link_clk_sync (link_clk_sync),
        .start         (turnaround_start && SERIAL_WIRE),
        .length        (st.turn),
        .active        (turn_active)
    );

    assign system_power_up_req   = st.sys_req;
    assign debug_power_up_req    = st.dbg_req;
    assign debug_reset_req       = st.rst_req;
    assign error_report_mode     = st.err_mode;
    assign overrun_detect_enable = st.orun_en;
    assign turnaround_length     = st.turn;
    assign turnaround_active     = turn_active;
    assign reg_rdata             = st.rdata;
    assign reg_rdata_valid       = st.rdata_valid;

    ////////////////////////////////////////////////////////////////////////////
    a_sys_ack_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE1
        reg_rd && hits(reg_addr, port_bank_select, dpc_pkg::BANK_CTRL)
        |=> reg_rdata[dpc_pkg::SYS_ACK_BIT] == $past(sys_ack))
        else $error("system ack readback wrong");
    a_sys_req_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE2
        wr_ctrl |=> system_power_up_req == $past(reg_wdata[dpc_pkg::SYS_REQ_BIT]))
        else $error("system request not taken from write");
    a_dbg_req_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE4
        wr_ctrl |=> debug_power_up_req == $past(reg_wdata[dpc_pkg::DBG_REQ_BIT]))
        else $error("debug power request not taken from write");
    a_rst_req_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE6
        wr_ctrl |=> debug_reset_req == $past(reg_wdata[dpc_pkg::RST_REQ_BIT]))
        else $error("debug reset request not taken from write");
    a_req_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE23
        !wr_ctrl |=> $stable(system_power_up_req) && $stable(debug_power_up_req)
                     && $stable(debug_reset_req))
        else $error("request changed without a write");
    a_err_mode_block: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE7
        st.err_mode && !st.sticky_err |=> !st.sticky_err)
        else $error("sticky error set while error mode is one");
    a_sticky_err_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE12
        ap_error && !st.err_mode |=> st.sticky_err)
        else $error("sticky error not set by port error");
    a_wde_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE8
        SERIAL_WIRE && write_data_error_event |=> st.wdata_err)
        else $error("write data error not flagged");
    a_wde_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE9
        st.wdata_err && !wde_clr |=> st.wdata_err)
        else $error("write data error cleared without abort");
    a_read_ok_track: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE10
        SERIAL_WIRE && read_resp_valid |=> st.read_ok == $past(read_resp_ok))
        else $error("read ok does not follow response");
    a_jtag_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE11
        !SERIAL_WIRE |-> !st.wdata_err && !st.read_ok)
        else $error("reserved bits nonzero in jtag variant");
    a_orun_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE15
        overrun_event && st.orun_en |=> st.sticky_orun)
        else $error("overrun not flagged");
    a_orun_abort: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE21
        abort_wr && abort_wdata[dpc_pkg::ABORT_ORUN_BIT] && !orun_set |=> !st.sticky_orun)
        else $error("abort did not clear overrun");
    a_target_one: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RULE19
        reg_rd && hits(reg_addr, port_bank_select, dpc_pkg::BANK_TARGET)
        |=> reg_rdata_valid && reg_rdata[dpc_pkg::TARGET_ONE_BIT])
        else $error("target ident bit 0 not one");
endmodule
`default_nettype wire

// [dpc_power_model.sv]
// Power and reset controller model with the debugger link clock source
`timescale 1ns/100ps
`default_nettype none
module dpc_power_model #(
    parameter int ACK_DELAY = 6
) (
    input  wire logic clk_sys,
    input  wire logic system_power_up_req,
    input  wire logic debug_power_up_req,
    input  wire logic debug_reset_req,
    input  wire logic link_run,
    output logic      system_power_up_ack,
    output logic      debug_power_up_ack,
    output logic      debug_reset_ack,
    output logic      link_clk
);
    logic [3*ACK_DELAY-1:0] hist = '0;
    // Slow on purpose: acks trail the requests by several cycles
    always @(posedge clk_sys) begin
        hist <= {hist[3*ACK_DELAY-4:0], system_power_up_req, debug_power_up_req, debug_reset_req};
    end
    assign {system_power_up_ack, debug_power_up_ack, debug_reset_ack} = hist[3*ACK_DELAY-1 -: 3];
    // Odd start offset puts every link clock edge 0.7ns before a system clock edge; parked low outside frames
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever begin
            #80;
            link_clk = link_run ? ~link_clk : 1'b0;
        end
    end
endmodule
`default_nettype wire

// [test_dpc_ctrl_status.sv]
// Self-checking bench for the debug port control and status registers
`timescale 1ns/100ps
`default_nettype none
module test_dpc_ctrl_status;
    logic        clk_sys, arst_n, reg_rd, reg_wr, abort_wr, link_clk, link_run, turn_act;
    logic        vld_s, vld_j, resp_ok;
    logic [3:0]  reg_addr, bank;
    logic [31:0] reg_wdata, abort_wdata, target_tie, rd_s, rd_j, got_s, got_j, seed;
    logic [4:0]  ev;
    logic [2:0]  req, ack;
    logic [1:0]  mode, turn_len;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cnt;

    dpc_ctrl_status #(.SERIAL_WIRE(1'b1)) u_dpc_ctrl_status (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .port_bank_select(bank), .abort_wr(abort_wr), .abort_wdata(abort_wdata),
        .ap_error(ev[0]), .overrun_event(ev[1]), .write_data_error_event(ev[2]),
        .read_resp_valid(ev[3]), .read_resp_ok(resp_ok), .system_power_up_ack(ack[2]),
        .debug_power_up_ack(ack[1]), .debug_reset_ack(ack[0]), .target_tie(target_tie),
        .link_clk(link_clk), .turnaround_start(ev[4]), .system_power_up_req(req[2]),
        .debug_power_up_req(req[1]), .debug_reset_req(req[0]), .error_report_mode(mode[1]),
        .overrun_detect_enable(mode[0]), .turnaround_length(turn_len),
        .turnaround_active(turn_act), .reg_rdata(rd_s), .reg_rdata_valid(vld_s));
    dpc_ctrl_status #(.SERIAL_WIRE(1'b0)) u_dpc_ctrl_status_jtag (.clk_sys(clk_sys),
        .arst_n(arst_n), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .port_bank_select(bank), .abort_wr(abort_wr),
        .abort_wdata(abort_wdata), .ap_error(ev[0]), .overrun_event(ev[1]),
        .write_data_error_event(ev[2]), .read_resp_valid(ev[3]), .read_resp_ok(resp_ok),
        .system_power_up_ack(ack[2]), .debug_power_up_ack(ack[1]), .debug_reset_ack(ack[0]),
        .target_tie(target_tie), .link_clk(link_clk), .turnaround_start(ev[4]),
        .system_power_up_req(), .debug_power_up_req(), .debug_reset_req(),
        .error_report_mode(), .overrun_detect_enable(), .turnaround_length(),
        .turnaround_active(), .reg_rdata(rd_j), .reg_rdata_valid(vld_j));
    dpc_power_model u_dpc_power_model (.clk_sys(clk_sys), .system_power_up_req(req[2]),
        .debug_power_up_req(req[1]), .debug_reset_req(req[0]), .link_run(link_run),
        .system_power_up_ack(ack[2]), .debug_power_up_ack(ack[1]), .debug_reset_ack(ack[0]),
        .link_clk(link_clk));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected link control word for a turnaround field value
    function automatic logic [31:0] link_exp(input logic [1:0] t);
        return {22'h0, t, 8'h40};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask
    // Strobes drop and an edge passes, so no strobe is driven twice in one step
    task automatic wr(input logic [3:0] b, input logic [31:0] d);
        bank = b; reg_wdata = d; reg_wr = 1'b1; step; reg_wr = 1'b0; step;
    endtask
    task automatic rd(input logic [3:0] b);
        bank = b; reg_rd = 1'b1; step; reg_rd = 1'b0;
        check({30'h0, vld_s, vld_j}, 32'h3);
        got_s = rd_s; got_j = rd_j; step;
    endtask
    task automatic pulse(input logic [4:0] e);
        ev = e; step; ev = 5'h00; step;
    endtask
    task automatic abort(input logic [31:0] d);
        abort_wdata = d; abort_wr = 1'b1; step; abort_wr = 1'b0; step;
    endtask
    task automatic wait_ack(input logic [2:0] want);
        cnt = 0;
        while (ack !== want && cnt < 100) begin step; cnt++; end
        if (ack !== want) begin n_mismatch++; $display("mismatch at %0t: no ack", $time); wrap_up; end
        repeat (3) step;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        arst_n = 1'b0; reg_rd = 1'b0; reg_wr = 1'b0; reg_addr = 4'h4; reg_wdata = 32'h0;
        bank = 4'h0; abort_wr = 1'b0; abort_wdata = 32'h0; ev = 5'h00; resp_ok = 1'b0;
        link_run = 1'b0; seed = 32'h0000_A280; target_tie = rnd();
        repeat (4) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        repeat (3) step;
        rd(4'h0); check(got_s, 32'h0); check(got_j, 32'h0);
        rd(4'h1); check(got_s, link_exp(dpc_pkg::TURN_RESET)); check(got_j, 32'h0);
        rd(4'h2); check(got_s, {target_tie[31:1], 1'b1});
        rd(4'h3); check(got_s, dpc_pkg::PROTOCOL_IDENT);
        check(got_j, dpc_pkg::PROTOCOL_IDENT);
        rd(4'h7); check(got_s, 32'h0); check(got_j, 32'h0);
        reg_addr = 4'h8; rd(4'h0); check(got_s, 32'h0); reg_addr = 4'h4;
        $display("reset values done");
        // Reserved bits carry random noise that must not stick
        wr(4'h0, (rnd() & 32'h02FF_FF1C) | 32'h5400_0000);
        check({29'h0, req}, 32'h7);
        wait_ack(3'b111);
        check({29'h0, req}, 32'h7);
        rd(4'h0); check(got_s, 32'hFC00_0000); check(got_j, 32'hFC00_0000);
        wr(4'h0, 32'h0); wait_ack(3'b000);
        rd(4'h0); check(got_s, 32'h0);
        $display("power handshake done");
        wr(4'h0, 32'h0100_0001); check({30'h0, mode}, 32'h3);
        pulse(5'h01); pulse(5'h02);
        rd(4'h0); check(got_s, 32'h0100_0003); check(got_j, 32'h0100_0003);
        wr(4'h0, 32'h0); abort(32'h10);
        rd(4'h0); check(got_s, 32'h0);
        pulse(5'h02); pulse(5'h01); wr(4'h0, 32'h1); pulse(5'h02);
        rd(4'h0); check(got_s, 32'h23); check(got_j, 32'h23);
        wr(4'h0, 32'h23);
        rd(4'h0); check(got_s, 32'h23); check(got_j, 32'h01);
        pulse(5'h03); abort(32'h04);
        rd(4'h0); check(got_s, 32'h03); check(got_j, 32'h03);
        abort(32'h10);
        rd(4'h0); check(got_s, 32'h01); check(got_j, 32'h01);
        $display("sticky flags done");
        // OK first, then not OK, so the clear of the read flag is seen
        for (int i = 1; i >= 0; i--) begin
            resp_ok = i[0]; pulse(5'h0C); wr(4'h0, 32'h1);
            rd(4'h0); check(got_s, {24'h0, 1'b1, i[0], 6'h01}); check(got_j, 32'h01);
            abort(32'h08);
            rd(4'h0); check(got_s, {25'h0, i[0], 6'h01});
        end
        $display("write error and read ok done");
        for (int n = 0; n < 4; n++) begin
            wr(4'h1, link_exp(n[1:0])); check({30'h0, turn_len}, n);
            rd(4'h1); check(got_s, link_exp(n[1:0])); check(got_j, 32'h0);
            link_run = 1'b1; ev = 5'h10; step; ev = 5'h00;
            cnt = 0;
            while (turn_act === 1'b1 && cnt < 200) begin step; cnt++; end
            // First synced edge after 2 to 11 cycles, then 20 cycles per period
            check({31'h0, cnt >= n * 20 + 2 && cnt <= n * 20 + 12}, 32'h1);
            // A stuck timer is already counted above
            if (cnt == 200) wrap_up;
            link_run = 1'b0; repeat (30) step;
        end
        $display("turnaround done");
        wrap_up;
    end
endmodule
`default_nettype wire
